// ### hdl/adc_ctrl_consts.svh
// Purpose: Named constants for the converter control register slice
// Assumes: 7-bit register address, 9-bit register data
// Notes:   Definitions only
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ****************************************
// Register addresses
// ****************************************
`define ADDR_LEFT_GAIN      7'h0E
`define ADDR_RIGHT_GAIN     7'h0F
`define ADDR_LEVEL_CTRL1    7'h10
`define ADDR_LEVEL_CTRL2    7'h11
`define ADDR_GATE           7'h13
`define ADDR_LIMITER        7'h14
`define ADDR_MIXER          7'h15
`define ADDR_SW_RESET       7'h17
// ****************************************
// Field positions
// ****************************************
`define GATE_ON_BIT         0
`define GATE_TH_HI          4
`define GATE_TH_LO          2
`define ATT_HI              3
`define ATT_LO              0
`define TWIN_HI             6
`define TWIN_LO             4
`define SEL_HI              3
`define SEL_LO              0
`define RMUTE_BIT           6
`define LMUTE_BIT           7
`define BOTH_BIT            8
`define GAIN_HI             7
`define GAIN_LO             0
`define FUNC_HI             8
`define FUNC_LO             7
`define LC_ON_BIT           8
// ****************************************
// Reset values and codes
// ****************************************
`define RST_GAIN            8'hCF
`define RST_GATE_TH         3'h0
`define RST_ATT             4'h6
`define RST_TWIN            3'h2
`define RST_SEL             4'h1
`define FUNC_LIMITER        2'h0
`define ATT_LIM_LOW         4'h3
`define ATT_LIM_HIGH        4'hC
`define ATT_LIM_BASE_DB     5'h03
`define ATT_ALC_LOW         4'hA
`define ATT_ALC_BASE_DB     5'h01
`define ATT_ALC_FIRST_DB    5'h05
`define ATT_ALC_STEP_DB     5'h04
`define GATE_TH_BASE_DB     7'h4E
`define GATE_TH_STEP_DB     7'h06
`endif

// ### hdl/adc_ctrl_pkg.sv
// Purpose: Types for the converter control register slice
// Assumes: Nothing beyond the constants header
// Notes:   Holds the one state struct
package adc_ctrl_pkg;
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic       gate_on;
      logic [2:0] gate_threshold;
      logic [3:0] attenuation_floor;
      logic [2:0] transient_window_len;
      logic [3:0] input_select;
      logic       right_mute;
      logic       left_mute;
      logic       gain_write_both;
      logic [7:0] left_gain;
      logic [7:0] right_gain;
      logic [1:0] level_func_select;
      logic       level_ctrl_on;
   } regs_t;
endpackage

// ### hdl/adc_gain_mux_control_regs.sv
// Purpose: Control registers for gate, limiter floor, window, input mux, mutes, gains
// Assumes: Serial control port decoded outside into a one-cycle write strobe
// Notes:   Write-only slice; decoded settings are combinational decodes of flip-flop state
//
// Operation
// - Gate enable bit 0 turns noise gate on, only while level control active and not in limiter mode.
// - Gate threshold bits 4:2 give -78 dBFS up to -36 dBFS in 6 dB steps.
// - Limiter floor: -3 dB up to code 0011, 1 dB per code, -12 dB max.
// - Level-control floor: -1 dB to 1010, -5 dB at 1011, then 4 dB steps.
// - Window bits 6:4: 000 off, 001 62.5 us, 010 125 us, 111 4 ms.
// - One-hot input select routes one of four input pairs to both channels.
// - Right mute bit 6 silences right channel while one.
// - Left mute bit 7 silences left channel while one.
// - With both-channels flag set, a gain write lands in both gain registers.
// - Any write to software reset register restores all registers; stores nothing.
// - Gain registers hold eight-bit codes in 0.5 dB steps, reset code CF.
// - Level-control enable turns limiter or level control on; gate, floor need it.
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"

module adc_gain_mux_control_regs
   import adc_ctrl_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       wr_en_i,
   input  wire logic [6:0] wr_addr_i,
   input  wire logic [8:0] wr_data_i,
   output logic            gate_active_o,
   output logic [6:0]      gate_threshold_dbfs_neg_o,
   output logic            level_active_o,
   output logic            limiter_mode_o,
   output logic [1:0]      level_func_select_o,
   output logic [4:0]      attenuation_floor_db_o,
   output logic [2:0]      transient_window_len_o,
   output logic            window_on_o,
   output logic [3:0]      input_pair_sel_o,
   output logic            input_sel_valid_o,
   output logic            right_mute_o,
   output logic            left_mute_o,
   output logic [7:0]      left_gain_o,
   output logic [7:0]      right_gain_o
);

   // ****************************************
   // Functions
   // ****************************************
   // Floor depth in dB below static gain, magnitude only
   function automatic logic [4:0] floor_db(input logic limiter, input logic [3:0] code);
      logic [4:0] v;
      v = 5'h00;
      if (limiter) begin
         if (code <= `ATT_LIM_LOW) v = `ATT_LIM_BASE_DB;
         else if (code >= `ATT_LIM_HIGH) v = {1'b0, `ATT_LIM_HIGH};
         else v = {1'b0, code};
      end else begin
         if (code <= `ATT_ALC_LOW) v = `ATT_ALC_BASE_DB;
         else v = 5'(`ATT_ALC_FIRST_DB
                  + `ATT_ALC_STEP_DB * 5'(code - `ATT_ALC_LOW - 4'h1));
      end
      return v;
   endfunction

   // A select with no bit or several bits set routes no pair
   function automatic logic one_hot4(input logic [3:0] s);
      return (s == 4'h1) || (s == 4'h2) || (s == 4'h4) || (s == 4'h8);
   endfunction

   // ****************************************
   // Reset synchroniser and state
   // ****************************************
   regs_t r_reg;
   regs_t r_next;
   logic  rst_n;

   assign rst_n = r_reg.sync2;

   function automatic regs_t reset_values(input regs_t cur);
      regs_t v;
      v = cur;
      v.gate_on              = 1'b0;
      v.gate_threshold       = `RST_GATE_TH;
      v.attenuation_floor    = `RST_ATT;
      v.transient_window_len = `RST_TWIN;
      v.input_select         = `RST_SEL;
      v.right_mute           = 1'b0;
      v.left_mute            = 1'b0;
      v.gain_write_both      = 1'b0;
      v.left_gain            = `RST_GAIN;
      v.right_gain           = `RST_GAIN;
      v.level_func_select    = `FUNC_LIMITER;
      v.level_ctrl_on        = 1'b0;
      return v;
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   // Unmapped or unknown addresses are ignored; bits outside fields are dropped
   always_comb begin
      r_next = r_reg;
      r_next.sync1 = 1'b1;
      r_next.sync2 = r_reg.sync1;
      if (!rst_n) begin
         r_next = reset_values(r_next);
      end else if (wr_en_i) begin
         unique case (wr_addr_i)
            `ADDR_GATE: begin
               r_next.gate_on        = wr_data_i[`GATE_ON_BIT];
               r_next.gate_threshold = wr_data_i[`GATE_TH_HI:`GATE_TH_LO];
            end
            `ADDR_LIMITER: begin
               r_next.attenuation_floor    = wr_data_i[`ATT_HI:`ATT_LO];
               r_next.transient_window_len = wr_data_i[`TWIN_HI:`TWIN_LO];
            end
            `ADDR_MIXER: begin
               r_next.input_select    = wr_data_i[`SEL_HI:`SEL_LO];
               r_next.right_mute      = wr_data_i[`RMUTE_BIT];
               r_next.left_mute       = wr_data_i[`LMUTE_BIT];
               r_next.gain_write_both = wr_data_i[`BOTH_BIT];
            end
            `ADDR_LEFT_GAIN: begin
               r_next.left_gain = wr_data_i[`GAIN_HI:`GAIN_LO];
               if (r_reg.gain_write_both) r_next.right_gain = wr_data_i[`GAIN_HI:`GAIN_LO];
            end
            `ADDR_RIGHT_GAIN: begin
               r_next.right_gain = wr_data_i[`GAIN_HI:`GAIN_LO];
               if (r_reg.gain_write_both) r_next.left_gain = wr_data_i[`GAIN_HI:`GAIN_LO];
            end
            `ADDR_LEVEL_CTRL1: begin
               r_next.level_func_select = wr_data_i[`FUNC_HI:`FUNC_LO];
            end
            `ADDR_LEVEL_CTRL2: begin
               r_next.level_ctrl_on = wr_data_i[`LC_ON_BIT];
            end
            `ADDR_SW_RESET: begin
               r_next = reset_values(r_next);
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************
   // Decoded outputs
   // ****************************************
   // Outputs derive only from registered state, so they hold steady between writes
   logic lim;
   assign lim = (r_reg.level_func_select == `FUNC_LIMITER);

   assign level_active_o            = r_reg.level_ctrl_on;
   assign gate_active_o             = r_reg.gate_on && r_reg.level_ctrl_on && !lim;
   assign gate_threshold_dbfs_neg_o = 7'(`GATE_TH_BASE_DB
                                      - `GATE_TH_STEP_DB * 7'(r_reg.gate_threshold));
   assign limiter_mode_o            = lim;
   assign level_func_select_o       = r_reg.level_func_select;
   assign attenuation_floor_db_o    = r_reg.level_ctrl_on
                                      ? floor_db(lim, r_reg.attenuation_floor) : 5'h00;
   assign transient_window_len_o    = r_reg.transient_window_len;
   assign window_on_o               = (r_reg.transient_window_len != 3'h0);
   assign input_pair_sel_o          = r_reg.input_select;
   assign input_sel_valid_o         = one_hot4(r_reg.input_select);
   assign right_mute_o              = r_reg.right_mute;
   assign left_mute_o               = r_reg.left_mute;
   assign left_gain_o               = r_reg.left_gain;
   assign right_gain_o              = r_reg.right_gain;

endmodule // adc_gain_mux_control_regs

// ### verif/adc_ctrl_regs_monitor.sv
// Purpose: Port assertions for the converter control register slice
// Assumes: First write comes four edges after reset release
// Notes:   Settings have no readback, so writes are tied to decoded outputs
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module adc_ctrl_regs_monitor (
   input wire logic       sys_clk_i,
   input wire logic       resetn_i,
   input wire logic       wr_en_i,
   input wire logic [6:0] wr_addr_i,
   input wire logic [8:0] wr_data_i,
   input wire logic       gate_active_o,
   input wire logic [6:0] gate_threshold_dbfs_neg_o,
   input wire logic       level_active_o,
   input wire logic       limiter_mode_o,
   input wire logic [1:0] level_func_select_o,
   input wire logic [4:0] attenuation_floor_db_o,
   input wire logic [2:0] transient_window_len_o,
   input wire logic       window_on_o,
   input wire logic [3:0] input_pair_sel_o,
   input wire logic       input_sel_valid_o,
   input wire logic       right_mute_o,
   input wire logic       left_mute_o,
   input wire logic [7:0] left_gain_o,
   input wire logic [7:0] right_gain_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   wire w_gate = wr_en_i && (wr_addr_i == `ADDR_GATE);
   wire w_lim  = wr_en_i && (wr_addr_i == `ADDR_LIMITER);
   wire w_mix  = wr_en_i && (wr_addr_i == `ADDR_MIXER);
   wire w_lg   = wr_en_i && (wr_addr_i == `ADDR_LEFT_GAIN);
   wire w_rst  = wr_en_i && (wr_addr_i == `ADDR_SW_RESET);
   // Floor magnitude in dB for either gain-control function
   function automatic logic [4:0] flr(input logic lim, input logic [3:0] c);
      if (lim) return (c <= 4'h3) ? 5'h03 : ((c >= 4'hC) ? 5'h0C : {1'b0, c});
      return (c <= 4'hA) ? 5'h01 : 5'(5'h05 + 5'h04 * ({1'b0, c} - 5'h0B));
   endfunction
   property p_gate;
      w_gate && level_active_o && !limiter_mode_o |=> gate_active_o == $past(wr_data_i[0]);
   endproperty
   a_gate: assert property (p_gate) else $error("gate enable not applied");
   property p_thr;
      w_gate |=> gate_threshold_dbfs_neg_o == 7'h4E - 7'h06 * {4'h0, $past(wr_data_i[4:2])};
   endproperty
   a_thr: assert property (p_thr) else $error("gate threshold wrong");
   property p_flr;
      w_lim && level_active_o |=>
         attenuation_floor_db_o == flr($past(limiter_mode_o), $past(wr_data_i[3:0]));
   endproperty
   a_flr: assert property (p_flr) else $error("attenuation floor wrong");
   property p_off;
      !level_active_o |-> attenuation_floor_db_o == 5'h00 && !gate_active_o;
   endproperty
   a_off: assert property (p_off) else $error("floor or gate live with control off");
   property p_win;
      w_lim |=> transient_window_len_o == $past(wr_data_i[6:4]) && window_on_o == |$past(wr_data_i[6:4]);
   endproperty
   a_win: assert property (p_win) else $error("window length wrong");
   property p_sel;
      w_mix |=> input_pair_sel_o == $past(wr_data_i[3:0]) && input_sel_valid_o == $onehot($past(wr_data_i[3:0]));
   endproperty
   a_sel: assert property (p_sel) else $error("input select wrong");
   property p_mute;
      w_mix |=> {left_mute_o, right_mute_o} == $past(wr_data_i[7:6]);
   endproperty
   a_mute: assert property (p_mute) else $error("mute bits wrong");
   property p_gain;
      w_lg |=> left_gain_o == $past(wr_data_i[7:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("left gain not stored");
   property p_rst;
      w_rst |=> {left_gain_o, right_gain_o, input_pair_sel_o, transient_window_len_o} == 23'h67_E78A
         && !left_mute_o && !right_mute_o && !level_active_o && gate_threshold_dbfs_neg_o == 7'h4E;
   endproperty
   a_rst: assert property (p_rst) else $error("software reset incomplete");
   c_both: cover property (w_lg ##1 left_gain_o == right_gain_o);
   c_gate: cover property (gate_active_o);
   c_rst: cover property (w_rst);
endmodule // adc_ctrl_regs_monitor
bind adc_gain_mux_control_regs adc_ctrl_regs_monitor adc_ctrl_regs_monitor_i (
   .sys_clk_i, .resetn_i, .wr_en_i, .wr_addr_i, .wr_data_i, .gate_active_o,
   .gate_threshold_dbfs_neg_o, .level_active_o, .limiter_mode_o, .level_func_select_o,
   .attenuation_floor_db_o, .transient_window_len_o, .window_on_o, .input_pair_sel_o,
   .input_sel_valid_o, .right_mute_o, .left_mute_o, .left_gain_o, .right_gain_o);

// ### verif/adc_gain_mux_control_regs_bench.sv
// Purpose: Self-checking bench for the converter control register slice
// Assumes: 100 MHz clock; inputs change at the falling edge
// Notes:   No readback exists, so every check reads the decoded outputs
`timescale 1ns/1ns
module adc_gain_mux_control_regs_bench;
   logic       sys_clk_i = 1'b0, resetn_i = 1'b0, wr_en_i = 1'b0;
   logic [6:0] wr_addr_i = 7'h00, gate_threshold_dbfs_neg_o;
   logic [8:0] wr_data_i = 9'h000;
   logic       gate_active_o, level_active_o, limiter_mode_o, window_on_o;
   logic       input_sel_valid_o, right_mute_o, left_mute_o;
   logic [1:0] level_func_select_o;
   logic [4:0] attenuation_floor_db_o;
   logic [2:0] transient_window_len_o;
   logic [3:0] input_pair_sel_o;
   logic [7:0] left_gain_o, right_gain_o;
   int         n_fail = 0, check_count = 0, cyc = 0, e = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   adc_gain_mux_control_regs adc_gain_mux_control_regs_i (.sys_clk_i, .resetn_i, .wr_en_i,
      .wr_addr_i, .wr_data_i, .gate_active_o, .gate_threshold_dbfs_neg_o, .level_active_o,
      .limiter_mode_o, .level_func_select_o, .attenuation_floor_db_o, .transient_window_len_o,
      .window_on_o, .input_pair_sel_o, .input_sel_valid_o, .right_mute_o, .left_mute_o,
      .left_gain_o, .right_gain_o);
   // Idle cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      wr_en_i = 1'b1;
      wr_addr_i = a;
      wr_data_i = d;
      @(negedge sys_clk_i);
      wr_en_i = 1'b0;
      @(negedge sys_clk_i);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rst;
      chk({left_gain_o, right_gain_o}, 16'hCFCF);
      chk({input_pair_sel_o, 1'b0, transient_window_len_o}, 16'h0012);
      chk({left_mute_o, right_mute_o, level_active_o, gate_active_o, attenuation_floor_db_o},
          16'h0000);
      chk(gate_threshold_dbfs_neg_o, 16'h004E);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Ceiling well above the roughly 135 cycles the tests need
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   // ********************************
   // Test sequence
   // ********************************
   initial begin
      repeat (4) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk_rst();
      $display("reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(7'h15, 9'h030 | (9'h001 << i));
         chk({input_sel_valid_o, input_pair_sel_o, left_mute_o, right_mute_o},
             16'(16'h0040 | (4 << i)));
      end
      wr(7'h15, 9'h003);
      chk(input_sel_valid_o, 16'h0000);
      wr(7'h15, 9'h041);
      chk({left_mute_o, right_mute_o}, 16'h0001);
      wr(7'h15, 9'h081);
      chk({left_mute_o, right_mute_o}, 16'h0002);
      $display("select and mute done");
      wr(7'h15, 9'h101);
      wr(7'h0E, 9'h050);
      chk({left_gain_o, right_gain_o}, 16'h5050);
      wr(7'h0F, 9'h133);
      chk({left_gain_o, right_gain_o}, 16'h3333);
      wr(7'h15, 9'h001);
      wr(7'h0E, 9'h011);
      chk({left_gain_o, right_gain_o}, 16'h1133);
      $display("gain write done");
      wr(7'h11, 9'h100);
      chk(level_active_o, 16'h0001);
      wr(7'h10, 9'h180);
      chk({limiter_mode_o, level_func_select_o}, 16'h0003);
      for (int c = 0; c < 8; c++) begin
         wr(7'h13, 9'(c * 4 + 1));
         chk({gate_active_o, gate_threshold_dbfs_neg_o}, 16'(8'hCE - 6 * c));
      end
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 16; c++) begin
            wr(7'h14, 9'(c + (c % 8) * 16));
            e = m ? ((c < 4) ? 3 : ((c > 11) ? 12 : c)) : ((c < 11) ? 1 : 5 + 4 * (c - 11));
            chk(attenuation_floor_db_o, 16'(e));
            chk({window_on_o, transient_window_len_o}, 16'(((c % 8) != 0) * 8 + c % 8));
         end
         wr(7'h10, 9'h000);
         chk({limiter_mode_o, level_func_select_o}, 16'h0004);
      end
      chk(gate_active_o, 16'h0000);
      wr(7'h11, 9'h000);
      chk(attenuation_floor_db_o, 16'h0000);
      $display("gate and floor done");
      // Move every mixer field off its reset value so the reset write has work to do
      wr(7'h15, 9'h1C2);
      chk({left_mute_o, right_mute_o, input_pair_sel_o}, 16'h0032);
      wr(7'h17, 9'h1FF);
      chk_rst();
      wr(7'h16, 9'h1FF);
      chk_rst();
      wr(7'h0E, 9'h011);
      chk({left_gain_o, right_gain_o}, 16'h11CF);
      wr(7'h11, 9'h100);
      chk({limiter_mode_o, level_func_select_o, attenuation_floor_db_o}, 16'h0086);
      wr(7'h10, 9'h180);
      chk(gate_active_o, 16'h0000);
      $display("software reset done");
      end_sim();
   end
endmodule // adc_gain_mux_control_regs_bench
